//--- hdl/sdwl_consts.svh
/*
  Constants shared by both ends of the serial converter word link.
  Assumes the 250 MHz sys_clk and that this header is included by bare name.
*/
`ifndef SDWL_CONSTS_SVH
`define SDWL_CONSTS_SVH

`define SDWL_WORD_BITS 16
`define SDWL_CNT_W 5
`define SDWL_MSB 15
`define SDWL_WORD_RESET 16'h0000
`define SDWL_BIPOLAR_ZERO 16'h8000
`define SDWL_CLK_PERIOD_NS 4
`define SDWL_SCK_HALF_NS 80
`define SDWL_SCK_HALF_CYC ((`SDWL_SCK_HALF_NS + `SDWL_CLK_PERIOD_NS - 1) / `SDWL_CLK_PERIOD_NS)
`define SDWL_DIV_W 8
`define SDWL_STROBE_GAP_CYC 16

`endif

//--- hdl/sdwl_device.sv
/*
  Converter end: shift register, word counter and converter latch.
  Assumes link pins are asynchronous to sys_clk and are synchronised here.
*/
`include "sdwl_consts.svh"

// Functional notes
// - Shift data on shift clock rise
// - Sixteen bits then select rise loads latch
// - Host keeps select low for sixteen shift clocks
// - Strobe falling edge loads latch
// - Host lowers strobe after select high
// - Host holds strobe high while shifting
// - Host keeps shift clock duty balanced
// - Reset clears converter latch to zero
// - Bipolar latch code is offset binary
module sdwl_device
  import sdwl_pkg::*;
(
  // System
  input wire logic sys_clk,
  input wire logic rst,
  // Link
  sdwl_if.dev link,
  // User side
  output sdwl_word_t dacCode,
  output logic dacBipolarCode,
  output logic wordLoaded
);

  // ***************************************************
  // State
  // ***************************************************
  sdwl_dev_t s_r;
  sdwl_dev_t s_nxt;

  logic selRise;
  logic selFall;
  logic sckRise;
  logic strobeFall;

  always_comb begin
    s_nxt = s_r;
    s_nxt.selSync = {s_r.selSync[0], link.selN};
    s_nxt.sckSync = {s_r.sckSync[0], link.sck};
    s_nxt.dinSync = {s_r.dinSync[0], link.din};
    s_nxt.strobeSync = {s_r.strobeSync[0], link.latchUpdateStrobeN};
    s_nxt.selPrev = s_r.selSync[1];
    s_nxt.sckPrev = s_r.sckSync[1];
    s_nxt.strobePrev = s_r.strobeSync[1];
    selFall = s_r.selPrev & ~s_r.selSync[1];
    selRise = ~s_r.selPrev & s_r.selSync[1];
    sckRise = ~s_r.sckPrev & s_r.sckSync[1];
    strobeFall = s_r.strobePrev & ~s_r.strobeSync[1];
    s_nxt.loaded = 1'b0;
    if (selFall) begin
      s_nxt.count = '0;
    end else if (~s_r.selSync[1] && sckRise) begin
      s_nxt.shift = {s_r.shift[`SDWL_MSB-1:0], s_r.dinSync[1]};
      if (s_r.count != `SDWL_CNT_W'(`SDWL_WORD_BITS)) begin
        s_nxt.count = s_r.count + `SDWL_CNT_W'(1);
      end
    end
    if (selRise && s_r.count == `SDWL_CNT_W'(`SDWL_WORD_BITS)) begin
      s_nxt.latch = s_r.shift;
      s_nxt.loaded = 1'b1;
    end else if (strobeFall && s_r.selSync[1]) begin
      s_nxt.latch = s_r.shift;
      s_nxt.loaded = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= '{selSync: 2'h3, sckSync: 2'h0, dinSync: 2'h0, strobeSync: 2'h3,
               selPrev: 1'b1, sckPrev: 1'b0, strobePrev: 1'b1,
               shift: `SDWL_WORD_RESET, count: '0,
               latch: `SDWL_WORD_RESET, loaded: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign dacCode = s_r.latch;
  assign dacBipolarCode = s_r.latch[`SDWL_MSB];
  assign wordLoaded = s_r.loaded;

endmodule

//--- hdl/sdwl_host.sv
/*
  Host end: sends one sixteen-bit word per request, optional strobe update.
  Assumes requests come from logic on sys_clk.
*/
`include "sdwl_consts.svh"

module sdwl_host
  import sdwl_pkg::*;
(
  // System
  input wire logic sys_clk,
  input wire logic rst,
  // Link
  sdwl_if.host link,
  // User side
  input wire logic sendReq,
  input sdwl_word_t sendWord,
  input wire logic sendUseStrobe,
  output logic busy,
  output logic done
);

  // ***************************************************
  // State
  // ***************************************************
  sdwl_host_t s_r;
  sdwl_host_t s_nxt;
  logic halfDone;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    halfDone = s_r.div == `SDWL_DIV_W'(`SDWL_SCK_HALF_CYC - 1);
    s_nxt.div = halfDone ? '0 : s_r.div + `SDWL_DIV_W'(1);
    case (s_r.state)
      SDWL_IDLE: begin
        s_nxt.div = '0;
        if (sendReq) begin
          s_nxt.shift = sendWord;
          s_nxt.useStrobe = sendUseStrobe;
          s_nxt.count = '0;
          s_nxt.selN = 1'b0;
          s_nxt.strobeN = 1'b1;
          s_nxt.busy = 1'b1;
          s_nxt.state = SDWL_SETUP;
        end
      end
      SDWL_SETUP: begin
        if (halfDone) begin
          s_nxt.din = s_r.shift[`SDWL_MSB];
          s_nxt.state = SDWL_LOW;
        end
      end
      SDWL_LOW: begin
        if (halfDone) begin
          s_nxt.sck = 1'b1;
          s_nxt.shift = {s_r.shift[`SDWL_MSB-1:0], 1'b0};
          s_nxt.count = s_r.count + `SDWL_CNT_W'(1);
          s_nxt.state = SDWL_HIGH;
        end
      end
      SDWL_HIGH: begin
        if (halfDone) begin
          s_nxt.sck = 1'b0;
          if (s_r.count == `SDWL_CNT_W'(`SDWL_WORD_BITS)) begin
            s_nxt.selN = 1'b1;
            s_nxt.state = s_r.useStrobe ? SDWL_STROBE : SDWL_IDLE;
            s_nxt.busy = s_r.useStrobe;
            s_nxt.done = ~s_r.useStrobe;
          end else begin
            s_nxt.din = s_r.shift[`SDWL_MSB];
            s_nxt.state = SDWL_LOW;
          end
        end
      end
      SDWL_STROBE: begin
        if (halfDone) begin
          if (s_r.strobeN) begin
            s_nxt.strobeN = 1'b0;
          end else begin
            s_nxt.strobeN = 1'b1;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
            s_nxt.state = SDWL_IDLE;
          end
        end
      end
      default: begin
        s_nxt.state = SDWL_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= '{state: SDWL_IDLE, shift: `SDWL_WORD_RESET, count: '0, div: '0,
               useStrobe: 1'b0, selN: 1'b1, sck: 1'b0, din: 1'b0,
               strobeN: 1'b1, busy: 1'b0, done: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign link.selN = s_r.selN;
  assign link.sck = s_r.sck;
  assign link.din = s_r.din;
  assign link.latchUpdateStrobeN = s_r.strobeN;
  assign busy = s_r.busy;
  assign done = s_r.done;

endmodule

//--- hdl/sdwl_if.sv
/*
  Link between host and converter: select, shift clock, data, update strobe.
  Assumes the host drives every wire and the converter only listens.
*/
interface sdwl_if;
  logic selN;
  logic sck;
  logic din;
  logic latchUpdateStrobeN;

  modport host (
    output selN,
    output sck,
    output din,
    output latchUpdateStrobeN
  );

  modport dev (
    input selN,
    input sck,
    input din,
    input latchUpdateStrobeN
  );
endinterface

//--- hdl/sdwl_pkg.sv
/*
  Types shared by both ends of the serial converter word link.
  Assumes sdwl_consts.svh is on the include path.
*/
`include "sdwl_consts.svh"

package sdwl_pkg;

  typedef logic [`SDWL_MSB:0] sdwl_word_t;

  typedef enum logic [4:0] {
    SDWL_IDLE = 5'h01,
    SDWL_SETUP = 5'h02,
    SDWL_LOW = 5'h04,
    SDWL_HIGH = 5'h08,
    SDWL_STROBE = 5'h10
  } sdwl_hstate_t;

  typedef struct packed {
    logic [1:0] selSync;
    logic [1:0] sckSync;
    logic [1:0] dinSync;
    logic [1:0] strobeSync;
    logic selPrev;
    logic sckPrev;
    logic strobePrev;
    sdwl_word_t shift;
    logic [`SDWL_CNT_W-1:0] count;
    sdwl_word_t latch;
    logic loaded;
  } sdwl_dev_t;

  typedef struct packed {
    sdwl_hstate_t state;
    sdwl_word_t shift;
    logic [`SDWL_CNT_W-1:0] count;
    logic [`SDWL_DIV_W-1:0] div;
    logic useStrobe;
    logic selN;
    logic sck;
    logic din;
    logic strobeN;
    logic busy;
    logic done;
  } sdwl_host_t;

endpackage

//--- tb/sdwl_checker.sv
/*
  Checker of the link wires between host and converter.
  Assumes instantiation beside the sdwl_if joining the two ends.
*/
module sdwl_checker (
  // System
  input wire logic sys_clk,
  input wire logic rst,
  // Link
  input wire logic selN,
  input wire logic sck,
  input wire logic din,
  input wire logic latchUpdateStrobeN
);
  // ********
  // Helpers
  // ********
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [4:0] hiCnt_r;
  logic [4:0] rises_r;
  logic sck_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hiCnt_r <= 5'h00;
      rises_r <= 5'h00;
      sck_r <= 1'b0;
    end else begin
      hiCnt_r <= sck ? hiCnt_r + 5'h01 : 5'h00;
      rises_r <= selN ? 5'h00 : rises_r + {4'h0, sck & !sck_r};
      sck_r <= sck;
    end
  end
  a_data_held: assert property ($rose(sck) |-> $stable(din))
    else $error("din moved at sck rise");
  a_select_setup: assert property ($fell(selN) |-> !sck [*8])
    else $error("sck high too soon after select");
  a_frame_sixteen: assert property ($rose(selN) |-> rises_r == 5'h10)
    else $error("frame not sixteen clocks");
  a_sck_idle_low: assert property (selN |-> !sck)
    else $error("sck high outside frame");
  a_duty_band: assert property ($fell(sck) |-> hiCnt_r inside {[16:24]})
    else $error("sck high time out of band");
  a_strobe_high_frame: assert property (!selN |-> latchUpdateStrobeN)
    else $error("strobe low during frame");
  a_strobe_after_sel: assert property ($fell(latchUpdateStrobeN) |->
    selN && $past(selN))
    else $error("strobe fell without select high");
  a_strobe_width: assert property ($fell(latchUpdateStrobeN) |->
    !latchUpdateStrobeN [*8] ##[1:40] latchUpdateStrobeN)
    else $error("strobe pulse width wrong");
  c_frame: cover property ($rose(selN));
  c_strobe: cover property ($fell(latchUpdateStrobeN));
  c_one_bit: cover property ($rose(sck) && din);
endmodule

//--- tb/serial_dac_word_loader_test.sv
/*
  Bench joining host and converter, plus a converter fed by the bench.
  Assumes the package, interface and both ends are compiled first.
*/
module serial_dac_word_loader_test import sdwl_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sendReq = 1'b0;
  logic sendUseStrobe = 1'b0;
  logic busy, done, dacBipolarCode, wordLoaded, bip2, wl2;
  sdwl_word_t sendWord = 16'h0000;
  sdwl_word_t dacCode, dacCode2;
  sdwl_word_t words [4] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0001};
  int bad_count = 0;
  int n_checks = 0;
  int loads = 0;
  int loads2 = 0;
  always #2 sys_clk = ~sys_clk;
  sdwl_if lk ();
  sdwl_if lk2 ();
  sdwl_host u_sdwl_host (.sys_clk, .rst, .link(lk), .sendReq, .sendWord, .sendUseStrobe,
    .busy, .done);
  sdwl_device u_sdwl_device (.sys_clk, .rst, .link(lk), .dacCode, .dacBipolarCode, .wordLoaded);
  sdwl_device u_sdwl_device_f (.sys_clk, .rst, .link(lk2), .dacCode(dacCode2),
    .dacBipolarCode(bip2), .wordLoaded(wl2));
  sdwl_checker u_sdwl_checker (.sys_clk, .rst, .selN(lk.selN), .sck(lk.sck), .din(lk.din),
    .latchUpdateStrobeN(lk.latchUpdateStrobeN));
  always @(posedge sys_clk) if (wordLoaded === 1'b1) loads++;
  always @(posedge sys_clk) if (wl2 === 1'b1) loads2++;
  // ******
  // Tasks
  // ******
  task automatic chk(input sdwl_word_t got, input sdwl_word_t exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic send(input sdwl_word_t w, input logic s);
    int c;
    c = loads;
    sendReq = 1'b1;
    sendWord = w;
    sendUseStrobe = s;
    cyc(1);
    sendReq = 1'b0;
    chk({15'h0, busy}, 16'h0001);
    for (int i = 0; i < 2000 && done !== 1'b1; i++) cyc(1);
    chk({15'h0, done}, 16'h0001);
    chk({15'h0, busy}, 16'h0000);
    cyc(12);
    chk(dacCode, w);
    chk({15'h0, dacBipolarCode}, {15'h0, w[15]});
    chk(16'(loads - c), s ? 16'h0002 : 16'h0001);
  endtask
  task automatic frame(input sdwl_word_t v, input int n);
    lk2.selN = 1'b0;
    cyc(20);
    for (int i = 0; i < n; i++) begin
      lk2.din = v[15 - i];
      cyc(20);
      lk2.sck = 1'b1;
      cyc(20);
      lk2.sck = 1'b0;
    end
    cyc(20);
    lk2.selN = 1'b1;
    lk2.din = ~lk2.din;
    cyc(20);
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    end_sim;
  end
  initial begin
    lk2.selN = 1'b1;
    lk2.sck = 1'b0;
    lk2.din = 1'b0;
    lk2.latchUpdateStrobeN = 1'b1;
    cyc(6);
    rst = 1'b0;
    cyc(2);
    chk(dacCode, 16'h0000);
    foreach (words[i]) send(words[i], i % 2 == 1);
    frame(16'h1234, 16);
    chk(dacCode2, 16'h1234);
    chk({15'h0, bip2}, 16'h0000);
    frame(16'h5a00, 8);
    chk(dacCode2, 16'h1234);
    lk2.latchUpdateStrobeN = 1'b0;
    cyc(20);
    lk2.latchUpdateStrobeN = 1'b1;
    cyc(10);
    chk(dacCode2, 16'h345a);
    chk(16'(loads2), 16'h0002);
    end_sim;
  end
endmodule
